/* rtl/umc_pkg.sv */
// Purpose: Shared constants for the modem handshake control block
// Assumes: 32-bit classic Wishbone, registers on word addresses
// Notes: Register index times four gives the byte address
package umc_pkg;

    // Register indices and byte addresses
    localparam logic [7:0] UMC_IDX_CTRL = 8'h04;
    localparam logic [7:0] UMC_IDX_EVT_STATUS = 8'h08;
    localparam logic [7:0] UMC_IDX_EVT_MASK = 8'h09;
    localparam logic [7:0] UMC_IDX_LINE_STATE = 8'h0A;
    localparam int UMC_ADDR_W = 8;
    localparam logic [UMC_ADDR_W-1:0] UMC_ADDR_CTRL = UMC_ADDR_W'({UMC_IDX_CTRL, 2'b00});
    localparam logic [UMC_ADDR_W-1:0] UMC_ADDR_EVT_STATUS =
        UMC_ADDR_W'({UMC_IDX_EVT_STATUS, 2'b00});
    localparam logic [UMC_ADDR_W-1:0] UMC_ADDR_EVT_MASK = UMC_ADDR_W'({UMC_IDX_EVT_MASK, 2'b00});
    localparam logic [UMC_ADDR_W-1:0] UMC_ADDR_LINE_STATE =
        UMC_ADDR_W'({UMC_IDX_LINE_STATE, 2'b00});

    // Control register layout
    localparam int UMC_CTRL_W = 8;
    localparam int UMC_CTRL_USED_W = 5;
    localparam int UMC_BIT_TERM_READY = 0;
    localparam int UMC_BIT_SEND_REQ = 1;
    localparam int UMC_BIT_SPARE = 2;
    localparam int UMC_BIT_IRQ_GATE = 3;
    localparam int UMC_BIT_LOOPBACK = 4;
    localparam logic [UMC_CTRL_USED_W-1:0] UMC_CTRL_RESET = 5'h00;

    // Event register layout, one bit per modem input change
    localparam int UMC_EVT_W = 4;
    localparam int UMC_EVT_CLEAR_SEND = 0;
    localparam int UMC_EVT_SET_READY = 1;
    localparam int UMC_EVT_RING_END = 2;
    localparam int UMC_EVT_CARRIER = 3;
    localparam logic [UMC_EVT_W-1:0] UMC_EVT_RESET = 4'h0;
    localparam logic [UMC_EVT_W-1:0] UMC_MASK_RESET = 4'h0;

    // Line state view layout
    localparam int UMC_LS_LOOPBACK = 4;
    localparam int UMC_LS_SERIAL_IN = 5;
    localparam int UMC_LS_W = 6;

endpackage

/* rtl/umc_loop_mux.sv */
// Purpose: Loopback steering between pins, shift registers and controls
// Assumes: All handshake pins are active low, controls active high
// Notes: Purely combinational; the parent registers the pin outputs
`timescale 1ns/100ps
module umc_loop_mux
    import umc_pkg::*;
(
    // Mode and controls
    input wire logic loopback_i,
    input wire logic [3:0] ctrl_i,
    // Serial data
    input wire logic tsr_out_i,
    input wire logic rxd_pin_i,
    output logic txd_o,
    output logic rsr_in_o,
    // Handshake pins, active low
    input wire logic clear_send_n_pin_i,
    input wire logic set_ready_n_pin_i,
    input wire logic ring_ind_n_pin_i,
    input wire logic carrier_det_n_pin_i,
    output logic terminal_ready_n_o,
    output logic send_request_n_o,
    // Effective modem inputs, active high
    output logic clear_send_o,
    output logic set_ready_o,
    output logic ring_ind_o,
    output logic carrier_det_o
);

    // Serial path: marking line out, transmitter looped into receiver
    always_comb begin
        txd_o = loopback_i ? 1'b1 : tsr_out_i; // R1
        rsr_in_o = loopback_i ? tsr_out_i : rxd_pin_i; // R2 R3
    end

    // Handshake outputs idle high in loopback, else inverse of control
    always_comb begin
        terminal_ready_n_o = loopback_i ? 1'b1 : ~ctrl_i[UMC_BIT_TERM_READY]; // R6 R11
        send_request_n_o = loopback_i ? 1'b1 : ~ctrl_i[UMC_BIT_SEND_REQ]; // R6 R12
    end

    // Inputs come from control bits in loopback, pins ignored
    always_comb begin
        if (loopback_i) begin
            set_ready_o = ctrl_i[UMC_BIT_TERM_READY]; // R4 R5
            clear_send_o = ctrl_i[UMC_BIT_SEND_REQ]; // R4 R5
            ring_ind_o = ctrl_i[UMC_BIT_SPARE]; // R5 R10
            carrier_det_o = ctrl_i[UMC_BIT_IRQ_GATE]; // R5
        end else begin
            set_ready_o = ~set_ready_n_pin_i;
            clear_send_o = ~clear_send_n_pin_i;
            ring_ind_o = ~ring_ind_n_pin_i;
            carrier_det_o = ~carrier_det_n_pin_i;
        end
    end

endmodule

/* rtl/umc_modem_ctrl.sv */
// Purpose: Modem handshake control register with diagnostic loopback
// Assumes: Classic Wishbone slave, 32-bit data, one clock, sync reset
// Notes: Modem input changes raise maskable events on the interrupt pin
//
// Behaviour
// R1 - In loopback the serial transmit pin is held at marking level one.
// R2 - In loopback the external serial receive pin has no effect.
// R3 - In loopback transmitter shift output feeds the receiver shift input.
// R4 - In loopback the four external handshake input pins are ignored.
// R5 - Loopback maps terminal-ready, send-request, spare, gate onto ready, clear, ring, carrier.
// R6 - In loopback both handshake output pins sit inactive high.
// R7 - Receiver and transmitter interrupts keep working in loopback, still enable-gated.
// R8 - Loopback modem interrupts come from control bits 3:0, still enable-gated.
// R9 - Control bit 3 low floats the interrupt pin; high enables it.
// R10 - Control bit 2 is plain storage, no pin, used only in loopback.
// R11 - Outside loopback terminal-ready pin is the inverse of control bit 0.
// R12 - Outside loopback send-request pin is the inverse of control bit 1.
// R13 - Control bits 7:5 read zero and ignore writes.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
module umc_modem_ctrl
    import umc_pkg::*;
#(
    parameter int ADDR_W = UMC_ADDR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial data to and from the shift registers
    input wire logic tsr_out_i,
    output logic rsr_in_o,
    // Serial pins
    input wire logic rxd_pin_i,
    output logic txd_pin_o,
    // Handshake pins, active low
    input wire logic clear_send_n_pin_i,
    input wire logic set_ready_n_pin_i,
    input wire logic ring_ind_n_pin_i,
    input wire logic carrier_det_n_pin_i,
    output logic terminal_ready_n_pin_o,
    output logic send_request_n_pin_o,
    // Interrupt sources from the rest of the port
    input wire logic core_irq_i,
    input wire logic modem_irq_en_i,
    // Serial port interrupt pin, three-state
    output logic irq_o,
    output logic irq_oe_o
);

    // Control register state
    logic [UMC_CTRL_USED_W-1:0] handshake_control_reg;
    logic [UMC_CTRL_USED_W-1:0] next_handshake_control_reg;

    // Event state
    logic [UMC_EVT_W-1:0] evt_status;
    logic [UMC_EVT_W-1:0] next_evt_status;
    logic [UMC_EVT_W-1:0] evt_mask;
    logic [UMC_EVT_W-1:0] next_evt_mask;
    logic [UMC_EVT_W-1:0] inputs_prev;
    logic [UMC_EVT_W-1:0] next_inputs_prev;
    logic [UMC_EVT_W-1:0] evt_raise;

    // Bus state
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // Pin output registers
    logic txd_q;
    logic next_txd_q;
    logic term_ready_n_q;
    logic next_term_ready_n_q;
    logic send_req_n_q;
    logic next_send_req_n_q;
    logic irq_q;
    logic next_irq_q;
    logic irq_oe_q;
    logic next_irq_oe_q;

    // Steering results
    logic loopback;
    logic irq_output_gate;
    logic spare_user_bit;
    logic txd_mux;
    logic term_ready_n_mux;
    logic send_req_n_mux;
    logic clear_send_eff;
    logic set_ready_eff;
    logic ring_ind_eff;
    logic carrier_det_eff;
    logic [UMC_EVT_W-1:0] inputs_now;

    // Decoded bus access
    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic lane0;

    assign loopback = handshake_control_reg[UMC_BIT_LOOPBACK];
    assign irq_output_gate = handshake_control_reg[UMC_BIT_IRQ_GATE];
    assign spare_user_bit = handshake_control_reg[UMC_BIT_SPARE]; // R10

    // Loopback steering kept in one place for both paths
    umc_loop_mux u_loop_mux (
        .loopback_i(loopback),
        .ctrl_i({irq_output_gate, spare_user_bit, handshake_control_reg[1:0]}),
        .tsr_out_i(tsr_out_i),
        .rxd_pin_i(rxd_pin_i),
        .txd_o(txd_mux),
        .rsr_in_o(rsr_in_o),
        .clear_send_n_pin_i(clear_send_n_pin_i),
        .set_ready_n_pin_i(set_ready_n_pin_i),
        .ring_ind_n_pin_i(ring_ind_n_pin_i),
        .carrier_det_n_pin_i(carrier_det_n_pin_i),
        .terminal_ready_n_o(term_ready_n_mux),
        .send_request_n_o(send_req_n_mux),
        .clear_send_o(clear_send_eff),
        .set_ready_o(set_ready_eff),
        .ring_ind_o(ring_ind_eff),
        .carrier_det_o(carrier_det_eff)
    );

    // Effective inputs in event bit order
    always_comb begin
        inputs_now = '0;
        inputs_now[UMC_EVT_CLEAR_SEND] = clear_send_eff;
        inputs_now[UMC_EVT_SET_READY] = set_ready_eff;
        inputs_now[UMC_EVT_RING_END] = ring_ind_eff;
        inputs_now[UMC_EVT_CARRIER] = carrier_det_eff;
    end

    // Bus decode; a single cycle answer per request
    always_comb begin
        bus_req = wb_cyc_i & wb_stb_i & ~ack;
        wr_en = bus_req & wb_we_i;
        rd_en = bus_req & ~wb_we_i;
        lane0 = wb_sel_i[0];
    end

    // Change detection; ring counts only on its trailing edge
    always_comb begin
        next_inputs_prev = inputs_now;
        evt_raise = '0;
        evt_raise[UMC_EVT_CLEAR_SEND] = inputs_now[UMC_EVT_CLEAR_SEND] ^
            inputs_prev[UMC_EVT_CLEAR_SEND];
        evt_raise[UMC_EVT_SET_READY] = inputs_now[UMC_EVT_SET_READY] ^
            inputs_prev[UMC_EVT_SET_READY];
        evt_raise[UMC_EVT_RING_END] = ~inputs_now[UMC_EVT_RING_END] &
            inputs_prev[UMC_EVT_RING_END];
        evt_raise[UMC_EVT_CARRIER] = inputs_now[UMC_EVT_CARRIER] ^
            inputs_prev[UMC_EVT_CARRIER];
    end

    // Control register: only the five live bits are stored
    always_comb begin
        next_handshake_control_reg = handshake_control_reg;
        if (wr_en && lane0 && wb_adr_i == ADDR_W'(UMC_ADDR_CTRL)) begin
            next_handshake_control_reg = wb_dat_i[UMC_CTRL_USED_W-1:0]; // R13
        end
    end

    // Sticky events; a new event beats a same-cycle clear
    always_comb begin
        next_evt_status = evt_status;
        if (wr_en && lane0 && wb_adr_i == ADDR_W'(UMC_ADDR_EVT_STATUS)) begin
            next_evt_status = evt_status & ~wb_dat_i[UMC_EVT_W-1:0];
        end
        next_evt_status = next_evt_status | evt_raise; // R8
    end

    // Event mask register
    always_comb begin
        next_evt_mask = evt_mask;
        if (wr_en && lane0 && wb_adr_i == ADDR_W'(UMC_ADDR_EVT_MASK)) begin
            next_evt_mask = wb_dat_i[UMC_EVT_W-1:0];
        end
    end

    // Read mux; unmapped words and reserved bits read as zero
    always_comb begin
        next_rdata = '0;
        if (rd_en) begin
            case (wb_adr_i)
                ADDR_W'(UMC_ADDR_CTRL): begin
                    next_rdata[UMC_CTRL_USED_W-1:0] = handshake_control_reg; // R13
                end
                ADDR_W'(UMC_ADDR_EVT_STATUS): begin
                    next_rdata[UMC_EVT_W-1:0] = evt_status;
                end
                ADDR_W'(UMC_ADDR_EVT_MASK): begin
                    next_rdata[UMC_EVT_W-1:0] = evt_mask;
                end
                ADDR_W'(UMC_ADDR_LINE_STATE): begin
                    next_rdata[UMC_EVT_W-1:0] = inputs_now;
                    next_rdata[UMC_LS_LOOPBACK] = loopback;
                    next_rdata[UMC_LS_SERIAL_IN] = rsr_in_o;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // Every request is acknowledged, mapped or not, so no bus hang
    always_comb begin
        next_ack = bus_req;
    end

    // Pins registered so they never glitch on a control write
    always_comb begin
        next_txd_q = txd_mux; // R1
        next_term_ready_n_q = term_ready_n_mux; // R6
        next_send_req_n_q = send_req_n_mux; // R6
    end

    // Interrupt: core sources untouched by loopback, modem events enable-gated
    always_comb begin
        next_irq_q = core_irq_i | (modem_irq_en_i & |(evt_status & evt_mask)); // R7 R8
        next_irq_oe_q = irq_output_gate; // R9
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            handshake_control_reg <= UMC_CTRL_RESET;
            evt_status <= UMC_EVT_RESET;
            evt_mask <= UMC_MASK_RESET;
            inputs_prev <= '0;
            ack <= 1'b0;
            rdata <= '0;
            txd_q <= 1'b1;
            term_ready_n_q <= 1'b1;
            send_req_n_q <= 1'b1;
            irq_q <= 1'b0;
            irq_oe_q <= 1'b0;
        end else begin
            handshake_control_reg <= next_handshake_control_reg;
            evt_status <= next_evt_status;
            evt_mask <= next_evt_mask;
            inputs_prev <= next_inputs_prev;
            ack <= next_ack;
            rdata <= next_rdata;
            txd_q <= next_txd_q;
            term_ready_n_q <= next_term_ready_n_q;
            send_req_n_q <= next_send_req_n_q;
            irq_q <= next_irq_q;
            irq_oe_q <= next_irq_oe_q;
        end
    end

    // Outputs
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign txd_pin_o = txd_q;
    assign terminal_ready_n_pin_o = term_ready_n_q;
    assign send_request_n_pin_o = send_req_n_q;
    // Level kept low while floated so a pull-up defines the wire
    assign irq_o = irq_q & irq_oe_q; // R9
    assign irq_oe_o = irq_oe_q; // R9

endmodule

/* testbench/umc_modem_ctrl_properties.sv */
// Purpose: Port checks for the modem handshake control block
// Assumes: A shadow of the control register follows accepted writes
// Notes: Pins are judged one cycle after the register changes
`timescale 1ns/100ps
module umc_modem_ctrl_properties
    import umc_pkg::*;
#(
    parameter int ADDR_W = UMC_ADDR_W
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Serial and handshake
    input wire logic tsr_out_i,
    input wire logic rsr_in_o,
    input wire logic txd_pin_o,
    input wire logic terminal_ready_n_pin_o,
    input wire logic send_request_n_pin_o,
    // Interrupt
    input wire logic core_irq_i,
    input wire logic irq_o,
    input wire logic irq_oe_o
);
    logic [4:0] ctrl;
    logic [4:0] next_ctrl;

    // Shadow loads at the accepting edge, as the register does
    always_comb begin
        next_ctrl = ctrl;
        if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i == UMC_ADDR_CTRL) begin
            next_ctrl = wb_dat_i[4:0];
        end
    end

    // Shadow register
    always_ff @(posedge clk_i) begin
        ctrl <= rst_i ? UMC_CTRL_RESET : next_ctrl;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    txd_mark_a: assert property (ctrl[4] |=> txd_pin_o)
        else $error("transmit pin not marking in loopback");
    loop_rx_a: assert property (ctrl[4] |-> rsr_in_o == tsr_out_i)
        else $error("receiver input not looped");
    pins_idle_a: assert property (ctrl[4] |=> terminal_ready_n_pin_o && send_request_n_pin_o)
        else $error("handshake pins active in loopback");
    ready_pin_a: assert property (!ctrl[4] |=> terminal_ready_n_pin_o == !$past(ctrl[0]))
        else $error("terminal ready pin wrong");
    request_pin_a: assert property (!ctrl[4] |=> send_request_n_pin_o == !$past(ctrl[1]))
        else $error("send request pin wrong");
    irq_gate_a: assert property (1'b1 |=> irq_oe_o == $past(ctrl[3]))
        else $error("interrupt enable not following gate bit");
    irq_float_a: assert property (!irq_oe_o |-> !irq_o)
        else $error("interrupt driven while floated");
    core_irq_a: assert property (core_irq_i && ctrl[3] |=> irq_o)
        else $error("core interrupt lost");
    ctrl_read_a: assert property (wb_cyc_i && wb_ack_o && !wb_we_i && wb_adr_i == UMC_ADDR_CTRL
        |-> wb_dat_o == {27'h0, ctrl})
        else $error("control readback wrong");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not a single pulse");
endmodule

bind umc_modem_ctrl umc_modem_ctrl_properties #(.ADDR_W(ADDR_W)) i_umc_props (.*);

/* testbench/umc_modem_model.sv */
// Purpose: Behavioural modem answering the handshake pins
// Assumes: Pins active low, bench commands active high
// Notes: Slow mode lags clear-to-send like a sluggish data set
`timescale 1ns/100ps
module umc_modem_model (
    // Clock and mode
    input wire logic clk_i,
    input wire logic slow_i,
    // Block outputs and bench commands
    input wire logic terminal_ready_n_i,
    input wire logic send_request_n_i,
    input wire logic ring_i,
    input wire logic carrier_i,
    // Block inputs
    output logic clear_send_n_o = 1'b1,
    output logic set_ready_n_o = 1'b1,
    output logic ring_ind_n_o = 1'b1,
    output logic carrier_det_n_o = 1'b1
);
    logic [2:0] lag = 3'h7;

    // Ready answers ready; clear-to-send follows the request
    always_ff @(posedge clk_i) begin
        lag <= {lag[1:0], send_request_n_i};
        set_ready_n_o <= terminal_ready_n_i;
        clear_send_n_o <= slow_i ? lag[2] : send_request_n_i;
        ring_ind_n_o <= !ring_i;
        carrier_det_n_o <= !carrier_i;
    end
endmodule

/* testbench/umc_modem_ctrl_test.sv */
// Purpose: Directed bench for the modem handshake control block
// Assumes: One Wishbone master, one 250 MHz clock
// Notes: Inputs change by non-blocking assignment at rising edges
`timescale 1ns/100ps
module umc_modem_ctrl_test
    import umc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tsr = 1'b1, rxd = 1'b1;
    logic core_irq = 1'b0, irq_en = 1'b0, ring = 1'b0, carr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, wsel = 4'hF;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] dat_o, rd;
    logic ack, rsr, txd, cs_n, sr_n, rg_n, cd_n, tr_n, sq_n, irq, irq_oe;
    int n_mismatch = 0, total_checks = 0, cycles = 0;

    umc_modem_ctrl i_umc_modem_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .tsr_out_i(tsr), .rsr_in_o(rsr), .rxd_pin_i(rxd),
        .txd_pin_o(txd), .clear_send_n_pin_i(cs_n), .set_ready_n_pin_i(sr_n),
        .ring_ind_n_pin_i(rg_n), .carrier_det_n_pin_i(cd_n), .terminal_ready_n_pin_o(tr_n),
        .send_request_n_pin_o(sq_n), .core_irq_i(core_irq), .modem_irq_en_i(irq_en),
        .irq_o(irq), .irq_oe_o(irq_oe));
    umc_modem_model i_umc_modem_model (.clk_i(clk_i), .slow_i(1'b1),
        .terminal_ready_n_i(tr_n), .send_request_n_i(sq_n), .ring_i(ring), .carrier_i(carr),
        .clear_send_n_o(cs_n), .set_ready_n_o(sr_n), .ring_ind_n_o(rg_n),
        .carrier_det_n_o(cd_n));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // Hang guard, far above the hundred or so cycles needed
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h00000000);
        chk(n, e, rd);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl", UMC_ADDR_CTRL, 32'h0);
        rdchk("unmapped", 8'h2C, 32'h0);
        tick(2);
        chk("pins", 32'({tr_n, sq_n, txd, irq_oe}), 32'hE);
        wb(1'b1, UMC_ADDR_CTRL, 32'hE3);
        tsr <= 1'b0;
        tick(2);
        chk("pins", 32'({tr_n, sq_n, txd}), 32'h0);
        rdchk("ctrl", UMC_ADDR_CTRL, 32'h03);
        // Write without byte lane 0 must leave the register alone
        wsel = 4'hE;
        wb(1'b1, UMC_ADDR_CTRL, 32'h00);
        wsel = 4'hF;
        rdchk("lane", UMC_ADDR_CTRL, 32'h03);
        tick(6);
        rdchk("line", UMC_ADDR_LINE_STATE, 32'h23);
        rdchk("status", UMC_ADDR_EVT_STATUS, 32'h3);
        // Loopback with external lines active
        wb(1'b1, UMC_ADDR_EVT_MASK, 32'hF);
        wb(1'b1, UMC_ADDR_CTRL, 32'h1B);
        carr <= 1'b1;
        ring <= 1'b1;
        tick(3);
        chk("loop pins", 32'({tr_n, sq_n, txd, rsr}), 32'hE);
        rdchk("line", UMC_ADDR_LINE_STATE, 32'h1B);
        wb(1'b1, UMC_ADDR_CTRL, 32'h1F);
        wb(1'b1, UMC_ADDR_EVT_STATUS, 32'hF);
        wb(1'b1, UMC_ADDR_CTRL, 32'h1B);
        tick(3);
        chk("irq", 32'({irq_oe, irq}), 32'h2);
        @(posedge clk_i);
        irq_en <= 1'b1;
        tick(3);
        rdchk("status", UMC_ADDR_EVT_STATUS, 32'h4);
        chk("irq", 32'({irq_oe, irq}), 32'h3);
        wb(1'b1, UMC_ADDR_EVT_MASK, 32'h0);
        tick(3);
        chk("irq", 32'({irq_oe, irq}), 32'h2);
        @(posedge clk_i);
        core_irq <= 1'b1;
        tick(3);
        chk("irq", 32'({irq_oe, irq}), 32'h3);
        wb(1'b1, UMC_ADDR_CTRL, 32'h13);
        tick(3);
        chk("irq", 32'({irq_oe, irq}), 32'h0);
        wb(1'b1, UMC_ADDR_EVT_STATUS, 32'hF);
        core_irq <= 1'b0;
        rdchk("status", UMC_ADDR_EVT_STATUS, 32'h0);
        end_of_test();
    end
endmodule
